// [sim/asm_adc_src.sv]
// Converter stand-in feeding both sample channels.
// Assumes the bench reads its output at the same edges as the monitor.
`timescale 1ns/1ps
`default_nettype none
module asm_adc_src
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Samples toward the monitor
  output asm_pkg::asm_sample_t [1:0] sampleOut
);
  import asm_pkg::*;
  // ==========
  // New code every clock; the sweep reaches full-scale negative too
  logic [15:0] lfsrQ;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      lfsrQ <= 16'hace1;
    else
      lfsrQ <= {lfsrQ[14:0], lfsrQ[15] ^ lfsrQ[13] ^ lfsrQ[12] ^ lfsrQ[10]};
  end
  assign sampleOut[0] = lfsrQ[13:0];
  assign sampleOut[1] = {lfsrQ[7:0], lfsrQ[15:10]};
endmodule
`default_nettype wire

// [sim/asm_monitor_sva.sv]
// Port checker for asm_monitor, attached by bind.
// Assumes a single clock domain and sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "asm_cfg.svh"
module asm_monitor_sva
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire asm_pkg::asm_reg_req_t regReq,
  input wire asm_pkg::asm_reg_ans_t regAns,
  // Samples, thresholds, results
  input wire asm_pkg::asm_sample_t [1:0] sampleIn,
  input wire asm_pkg::asm_mag_t [1:0] thrUpper,
  input wire asm_pkg::asm_ser_t serOut
);
  import asm_pkg::*;
  // ==========
  // Helpers
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Sample magnitude, full-scale negative clipped to the top code
  function automatic asm_mag_t magOf(input asm_sample_t s);
    int v;
    v = s[13] ? 16384 - int'(s) : int'(s);
    return v > 8191 ? `ASM_MAG_MAX : 13'(v);
  endfunction
  logic [2:0] serQ;
  logic [7:0] gapQ;
  logic seenQ;
  // Serial enables as written; gap saturates so long idle spans stay legal
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serQ <= 3'h0;
      gapQ <= 8'h00;
      seenQ <= 1'b0;
    end
    else
    begin
      if (regReq.wrEn && regReq.addr == `ASM_ADDR_SER)
        serQ <= regReq.wrData[2:0];
      gapQ <= serOut.valid ? 8'h00 : gapQ + {7'h00, gapQ != 8'hff};
      seenQ <= seenQ | serOut.valid;
    end
  end
  // Period end is a lone pulse
  sequence endPulse;
    serOut.valid ##1 !serOut.valid;
  endsequence
  rd_answer_a: assert property (regReq.rdEn |=> regAns.rdValid)
    else $error("read not answered next cycle");
  rd_quiet_a: assert property (!regReq.rdEn |=> !regAns.rdValid)
    else $error("answer without read");
  rd_unmapped_a: assert property (regReq.rdEn && regReq.addr == 13'h0100
    |=> regAns.rdData == 8'h00) else $error("unmapped read not zero");
  res_top_a: assert property (regReq.rdEn && regReq.addr == `ASM_ADDR_RB2
    |=> regAns.rdData[7:4] == 4'h0) else $error("result wider than 20 bits");
  end_pulse_a: assert property ($rose(serOut.valid) |-> endPulse)
    else $error("result pulse too long");
  res_hold_a: assert property (!serOut.valid |-> $stable(serOut.rms)
    && $stable(serOut.peak) && $stable(serOut.thr)) else $error("result moved mid period");
  period_gap_a: assert property (serOut.valid && seenQ |-> gapQ >= 8'd127)
    else $error("period shorter than 128");
  ser_enables_a: assert property (serOut.valid
    |-> {serOut.thrEn, serOut.peakEn, serOut.rmsEn} == $past(serQ))
    else $error("serial enables not copied");
  // The boundary sample still belongs to the period that ends with it
  peak_floor_a: assert property (serOut.valid && serOut.peakEn
    |-> serOut.peak[0] >= magOf($past(sampleIn[0]))) else $error("peak below last sample");
  thr_count_a: assert property (serOut.valid && serOut.thrEn
    && magOf($past(sampleIn[1])) > $past(thrUpper[1]) |-> serOut.thr[1] != 20'h00000)
    else $error("crossing not counted");
endmodule
bind asm_monitor asm_monitor_sva chk (.ref_clk(ref_clk), .resetn(resetn), .regReq(regReq),
  .regAns(regAns), .sampleIn(sampleIn), .thrUpper(thrUpper), .serOut(serOut));
`default_nettype wire

// [sim/asm_monitor_tb_top.sv]
// Self-checking bench for the signal monitor: registers and period results.
// Assumes the sample source model drives the sample path.
`timescale 1ns/1ps
`default_nettype none
`include "asm_cfg.svh"
module asm_monitor_tb_top;
  import asm_pkg::*;
  logic ref_clk;
  logic resetn;
  asm_reg_req_t req;
  asm_reg_ans_t ans;
  asm_sample_t [1:0] period_sample_count;
  asm_mag_t [1:0] thr;
  asm_ser_t ser;
  asm_res_t [1:0] expResult;
  logic cpx;
  logic [7:0] expQ[$];
  int histA[$];
  int histB[$];
  int miscompares;
  int samples_checked;
  int nValid;
  int per;
  int n0;
  logic [23:0] pv;
  logic [2:0] sel;
  logic [1:0] mode;
  logic [20:0] rstTab[8] = '{{`ASM_ADDR_CTRL, 8'h00}, {`ASM_ADDR_PER0, 8'h80},
    {`ASM_ADDR_PER1, 8'h00}, {`ASM_ADDR_PER2, 8'h00}, {`ASM_ADDR_SER, 8'h00},
    {`ASM_ADDR_RA0, 8'h00}, {`ASM_ADDR_RB2, 8'h00}, {13'h0100, 8'h00}};
  // Control byte over serial enables
  logic [15:0] cfgTab[7] = '{16'h0100, 16'h0300, 16'h0500, 16'h0700, 16'h0106, 16'h0701,
    16'h0901};
  // ==========
  // Clock, design, sample source
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  asm_monitor DUT (.ref_clk(ref_clk), .resetn(resetn), .regReq(req), .regAns(ans),
    .sampleIn(period_sample_count), .thrUpper(thr), .serOut(ser));
  asm_adc_src src (.ref_clk(ref_clk), .resetn(resetn), .sampleOut(period_sample_count));
  task automatic fail(input string msg);
    miscompares++;
    $display("mismatch at %0t: %0s", $time, msg);
  endtask
  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
      fail($sformatf("read %h expected %h", got, exp));
  endtask
  task automatic cmpRes(input asm_res_t got, input asm_res_t exp);
    samples_checked++;
    if (got !== exp)
      fail($sformatf("result %h expected %h", got, exp));
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One-cycle strobes, launched and dropped on rising edges
  task automatic regWr(input logic [12:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic regRd(input logic [12:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge ref_clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic waitValid(input int n);
    int t0;
    t0 = nValid;
    for (int i = 0; i < 1000 && nValid < t0 + n; i++)
      @(posedge ref_clk);
    if (nValid < t0 + n)
    begin
      fail("no period result");
      conclude();
    end
  endtask
  function automatic int magOf(input asm_sample_t s);
    int m;
    m = s[13] ? int'(14'(~s + 14'h1)) : int'(s);
    return m > 8191 ? 8191 : m;
  endfunction
  function automatic logic [7:0] resByte(input int b);
    asm_res_t r;
    r = expResult[b / 3];
    return (b % 3 == 2) ? {4'h0, r[19:16]} : r[(b % 3) * 8 +: 8];
  endfunction
  // Expected results from the last per samples seen at the sampling edges
  task automatic check(input int c);
    int pk, cnt, acc, r, m, p;
    pk = 0;
    cnt = 0;
    acc = 0;
    r = 0;
    for (int i = histA.size() - per; i < histA.size(); i++)
    begin
      m = c ? histB[i] : histA[i];
      pk = m > pk ? m : pk;
      cnt += m > int'(thr[c]) ? 1 : 0;
      p = (m * m) >> 15;
      if (cpx && c == 0)
        p = p + ((histB[i] * histB[i]) >> 15);
      acc += p > 2047 ? 2047 : p;
      acc = acc > 'hffffff ? 'hffffff : acc;
    end
    while ((r + 1) * (r + 1) <= acc)
      r++;
    expResult[c] = mode == 2'b00 ? 20'(r << 8) : mode == 2'b01 ? 20'(pk) : 20'(cnt);
    if (sel[0])
      cmpRes(ser.rms[c], 20'(r << 8));
    if (sel[1])
      cmpRes(20'(ser.peak[c]), 20'(pk));
    if (sel[2])
      cmpRes(ser.thr[c], 20'(cnt));
  endtask
  // ==========
  // Watcher: read answers pop the note queue, period ends are predicted
  always @(posedge ref_clk)
  begin
    if (ans.rdValid === 1'b1)
    begin
      if (expQ.size() == 0)
        fail("unexpected read answer");
      else
        cmpByte(ans.rdData, expQ.pop_front());
    end
    if (ser.valid === 1'b1)
    begin
      nValid++;
      check(0);
      check(1);
    end
    histA.push_back(magOf(period_sample_count[0]));
    histB.push_back(magOf(period_sample_count[1]));
    if (histA.size() > 300)
    begin
      void'(histA.pop_front());
      void'(histB.pop_front());
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    req = '0;
    thr = '0;
    miscompares = 0;
    samples_checked = 0;
    nValid = 0;
    per = 128;
    sel = 3'h0;
    mode = 2'h0;
    cpx = 1'b0;
    void'($urandom(32'hdcff));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rstTab[i])
      regRd(rstTab[i][20:8], rstTab[i][7:0]);
    regWr(`ASM_ADDR_RA0, 8'hff);
    regRd(`ASM_ADDR_RA0, 8'h00);
    pv = 24'($urandom);
    regWr(`ASM_ADDR_PER1, pv[7:0]);
    regRd(`ASM_ADDR_PER1, pv[7:0]);
    $display("test registers done");
    // Stop, program period and thresholds, then enable each mode in turn
    foreach (cfgTab[k])
    begin
      regWr(`ASM_ADDR_CTRL, 8'h00);
      pv = (k == 1) ? 24'h000005 : 24'(128 + $urandom % 64);
      per = pv < 128 ? 128 : int'(pv);
      thr <= {13'($urandom), 13'($urandom)};
      regWr(`ASM_ADDR_PER0, pv[7:0]);
      regWr(`ASM_ADDR_PER1, pv[15:8]);
      regWr(`ASM_ADDR_PER2, pv[23:16]);
      regWr(`ASM_ADDR_SER, cfgTab[k][7:0]);
      mode = cfgTab[k][10:9];
      cpx = cfgTab[k][11];
      sel = cfgTab[k][2:0] | (mode[1] ? 3'b100 : mode[0] ? 3'b010 : 3'b001);
      regWr(`ASM_ADDR_CTRL, cfgTab[k][15:8]);
      waitValid(3);
      for (int b = 0; b < 6; b++)
        regRd(13'(`ASM_ADDR_RA0 + b), resByte(b));
      $display("test mode %0d done", k);
    end
    regWr(`ASM_ADDR_CTRL, 8'h00);
    n0 = nValid;
    repeat (300) @(posedge ref_clk);
    cmpRes(20'(nValid - n0), 20'h0);
    $display("test disable done");
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    regRd(`ASM_ADDR_PER0, 8'h80);
    regRd(`ASM_ADDR_RA0, 8'h00);
    repeat (3) @(posedge ref_clk);
    if (expQ.size() != 0)
      fail("read answer missing");
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire

// [src/asm_cfg.svh]
// Addresses, field positions, reset values and limits of the signal monitor.
// Assumes it is included by its bare name from the package and the modules.
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH

// ==========================================================================
// Register addresses
`define ASM_ADDR_CTRL 13'h0112
`define ASM_ADDR_PER0 13'h0113
`define ASM_ADDR_PER1 13'h0114
`define ASM_ADDR_PER2 13'h0115
`define ASM_ADDR_RA0 13'h0116
`define ASM_ADDR_RA1 13'h0117
`define ASM_ADDR_RA2 13'h0118
`define ASM_ADDR_RB0 13'h0119
`define ASM_ADDR_RB1 13'h011a
`define ASM_ADDR_RB2 13'h011b
`define ASM_ADDR_SER 13'h1111

// ==========================================================================
// Field positions
`define ASM_CTRL_EN 0
`define ASM_CTRL_MODE_LO 1
`define ASM_CTRL_MODE_HI 2
`define ASM_CTRL_CPX 3
`define ASM_SER_RMS 0
`define ASM_SER_PEAK 1
`define ASM_SER_THR 2
`define ASM_ON_RMS 0
`define ASM_ON_PEAK 1
`define ASM_ON_THR 2

// ==========================================================================
// Reset values and limits
`define ASM_RST_CTRL 8'h00
`define ASM_RST_SER 8'h00
`define ASM_RST_PERIOD 24'h000080
`define ASM_PERIOD_MIN 24'h000080
`define ASM_TIMER_LAST 24'h000001
`define ASM_MAG_MAX 13'h1fff
`define ASM_POW_MAX 11'h7ff
`define ASM_ACC_MAX 24'hffffff
`define ASM_RES_MAX 20'hfffff

`endif

// [src/asm_isqrt.sv]
// Integer square root of a 24-bit value, purely combinational.
// Assumes its output is registered by the instantiating module.
`timescale 1ns/1ps
`default_nettype none

module asm_isqrt
(
  // Operand
  input wire logic [23:0] radicand,
  // Result
  output logic [11:0] root
);

  logic [11:0] trial;
  logic [23:0] square;

  // Bit by bit from the top; a dozen small squares beat a long divider chain
  always_comb
  begin
    root = 12'h000;
    trial = 12'h000;
    square = 24'h000000;
    for (int i = 11; i >= 0; i--)
    begin
      trial = root;
      trial[i] = 1'b1;
      square = {12'h000, trial} * {12'h000, trial};
      if (square <= radicand)
      begin
        root = trial;
      end
    end
  end

endmodule

`default_nettype wire

// [src/asm_monitor.sv]
// Two-channel signal statistics monitor: peak, rms and threshold counts.
// Assumes samples and register strobes arrive on ref_clk from on-chip logic.
`timescale 1ns/1ps
`default_nettype none

`include "asm_cfg.svh"

module asm_monitor
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port from the serial configuration decoder
  input wire asm_pkg::asm_reg_req_t regReq,
  output asm_pkg::asm_reg_ans_t regAns,
  // Sample path, two's complement, one sample per clock per channel
  input wire asm_pkg::asm_sample_t [1:0] sampleIn,
  // Upper thresholds shared with the gain-control logic
  input wire asm_pkg::asm_mag_t [1:0] thrUpper,
  // Results toward the serial monitor output
  output asm_pkg::asm_ser_t serOut
);

  import asm_pkg::*;

  // ========================================================================
  // Helper functions

  // Which measurements run, as {thr, peak, rms}
  function automatic logic [2:0] modeOn(input logic [7:0] ctrl, input logic [7:0] ser);
    logic [2:0] on;
    on = 3'b000;
    on[`ASM_ON_RMS] = (ctrl[`ASM_CTRL_MODE_HI] == 1'b0 && ctrl[`ASM_CTRL_MODE_LO] == 1'b0)
      || ser[`ASM_SER_RMS];
    on[`ASM_ON_PEAK] = (ctrl[`ASM_CTRL_MODE_HI] == 1'b0 && ctrl[`ASM_CTRL_MODE_LO] == 1'b1)
      || ser[`ASM_SER_PEAK];
    on[`ASM_ON_THR] = ctrl[`ASM_CTRL_MODE_HI] || ser[`ASM_SER_THR];
    return on;
  endfunction

  // Magnitude of a sample, the one out-of-range code (full-scale negative) clipped to full scale
  function automatic asm_mag_t magOf(input asm_sample_t s);
    logic [13:0] a;
    a = s[13] ? (~s + 14'h0001) : s;
    return a[13] ? `ASM_MAG_MAX : a[12:0];
  endfunction

  // Square of a magnitude, kept as the top 11 bits of the 26-bit product
  function automatic logic [10:0] powOf(input asm_mag_t m);
    logic [25:0] sq;
    sq = {13'h0000, m} * {13'h0000, m};
    return sq[25:15];
  endfunction

  // Saturating 24-bit add of an 11-bit power
  function automatic logic [23:0] accAdd(input logic [23:0] a, input logic [10:0] p);
    logic [24:0] s;
    s = {1'b0, a} + {14'h0000, p};
    return s[24] ? `ASM_ACC_MAX : s[23:0];
  endfunction

  // Clip a 24-bit count into the 20-bit result
  function automatic asm_res_t clip20(input logic [23:0] c);
    return (c[23:20] != 4'h0) ? `ASM_RES_MAX : c[19:0];
  endfunction

  // Byte read decode; unmapped addresses read as zero
  function automatic logic [7:0] readByte(input asm_state_t s, input logic [12:0] addr);
    logic [7:0] r;
    r = 8'h00;
    case (addr)
      `ASM_ADDR_CTRL: r = s.ctrl;
      `ASM_ADDR_PER0: r = s.period[7:0];
      `ASM_ADDR_PER1: r = s.period[15:8];
      `ASM_ADDR_PER2: r = s.period[23:16];
      `ASM_ADDR_RA0: r = s.chan[0].monResult[7:0];
      `ASM_ADDR_RA1: r = s.chan[0].monResult[15:8];
      `ASM_ADDR_RA2: r = {4'h0, s.chan[0].monResult[19:16]};
      `ASM_ADDR_RB0: r = s.chan[1].monResult[7:0];
      `ASM_ADDR_RB1: r = s.chan[1].monResult[15:8];
      `ASM_ADDR_RB2: r = {4'h0, s.chan[1].monResult[19:16]};
      `ASM_ADDR_SER: r = s.serCtl;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ========================================================================
  // State

  asm_state_t q;
  asm_state_t d;

  asm_mag_t [1:0] mag;
  logic [1:0] [10:0] powRaw;
  logic [1:0] [10:0] pow;
  logic [1:0] above;
  asm_mag_t [1:0] peakNow;
  logic [1:0] [23:0] accNow;
  logic [1:0] [23:0] cntNow;
  logic [1:0] [11:0] root;
  logic [11:0] cpxSum;
  logic [23:0] periodEff;
  logic [2:0] onSet;
  logic enable;
  logic boundary;

  // ========================================================================
  // Per-sample datapath, one copy per channel

  // I^2 + Q^2 for channel A in complex mode, clipped to the 11-bit range
  assign cpxSum = {1'b0, powRaw[0]} + {1'b0, powRaw[1]};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gChan
      // Magnitude, power and threshold test of this cycle's sample
      assign mag[g] = magOf(sampleIn[g]);
      assign powRaw[g] = powOf(mag[g]);
      assign above[g] = (mag[g] > thrUpper[g]);

      // Running values including the current sample; first sample seeds them
      assign peakNow[g] = (q.first || mag[g] > q.chan[g].holder) ? mag[g]
        : q.chan[g].holder;
      assign accNow[g] = q.first ? {13'h0000, pow[g]} : accAdd(q.chan[g].acc, pow[g]);
      assign cntNow[g] = (q.chan[g].cnt == `ASM_ACC_MAX) ? q.chan[g].cnt
        : q.chan[g].cnt + {23'h000000, above[g]};

      // Root of the period's sum; registered at the boundary
      asm_isqrt uRoot
      (
        .radicand(accNow[g]),
        .root(root[g])
      );
    end
  endgenerate

  // Channel A power switches to the complex sum; channel B is unchanged
  assign pow[0] = q.ctrl[`ASM_CTRL_CPX] ? (cpxSum[11] ? `ASM_POW_MAX : cpxSum[10:0])
    : powRaw[0];
  assign pow[1] = powRaw[1];

  // Short periods raise to the floor; zero wraps and gives 2^24 cycles
  assign periodEff = (q.period != 24'h000000 && q.period < `ASM_PERIOD_MIN)
    ? `ASM_PERIOD_MIN : q.period;

  // Control decode
  assign onSet = modeOn(q.ctrl, q.serCtl);
  assign enable = q.ctrl[`ASM_CTRL_EN];
  assign boundary = (q.timer == `ASM_TIMER_LAST);

  // ========================================================================
  // Next-state logic

  always_comb
  begin
    d = q;
    d.ans.rdValid = 1'b0;
    d.ser.valid = 1'b0;
    d.onPrev = onSet;

    // Register writes; unmapped addresses are ignored
    if (regReq.wrEn)
    begin
      case (regReq.addr)
        `ASM_ADDR_CTRL: d.ctrl = regReq.wrData;
        `ASM_ADDR_PER0: d.period[7:0] = regReq.wrData;
        `ASM_ADDR_PER1: d.period[15:8] = regReq.wrData;
        `ASM_ADDR_PER2: d.period[23:16] = regReq.wrData;
        `ASM_ADDR_SER: d.serCtl = regReq.wrData;
        default: d.ctrl = q.ctrl;
      endcase
    end

    // Register reads, answered one cycle later from a flop
    if (regReq.rdEn)
    begin
      d.ans.rdValid = 1'b1;
      d.ans.rdData = readByte(q, regReq.addr);
    end

    // Measurement sequencing
    unique case (q.state)
      ASM_IDLE:
      begin
        if (enable)
        begin
          // Start: load the timer, count from the next sample
          d.state = ASM_RUN;
          d.timer = periodEff;
          d.first = 1'b1;
          for (int i = 0; i < 2; i++)
          begin
            d.chan[i].cnt = 24'h000000;
          end
        end
      end
      ASM_RUN:
      begin
        if (!enable)
        begin
          d.state = ASM_IDLE;
        end
        else if (onSet != q.onPrev)
        begin
          // Any change in the selected measurements restarts the period at once
          d.timer = periodEff;
          d.first = 1'b1;
          for (int i = 0; i < 2; i++)
          begin
            d.chan[i].cnt = 24'h000000;
          end
        end
        else if (boundary)
        begin
          // End of period: transfer results, reload, reseed on next sample
          d.timer = periodEff;
          d.first = 1'b1;
          d.ser.valid = 1'b1;
          d.ser.rmsEn = q.serCtl[`ASM_SER_RMS];
          d.ser.peakEn = q.serCtl[`ASM_SER_PEAK];
          d.ser.thrEn = q.serCtl[`ASM_SER_THR];
          for (int i = 0; i < 2; i++)
          begin
            if (onSet[`ASM_ON_PEAK])
            begin
              d.chan[i].peakRes = peakNow[i];
            end
            if (onSet[`ASM_ON_RMS])
            begin
              d.chan[i].rmsRes = {root[i], 8'h00};
            end
            if (onSet[`ASM_ON_THR])
            begin
              d.chan[i].thrRes = clip20(cntNow[i]);
            end
            d.chan[i].cnt = 24'h000000;
            d.chan[i].holder = peakNow[i];
            d.chan[i].acc = accNow[i];
            // Readable result follows the mode field, only here
            if (q.ctrl[`ASM_CTRL_MODE_HI])
            begin
              d.chan[i].monResult = clip20(cntNow[i]);
            end
            else if (q.ctrl[`ASM_CTRL_MODE_LO])
            begin
              d.chan[i].monResult = {7'h00, peakNow[i]};
            end
            else
            begin
              d.chan[i].monResult = {root[i], 8'h00};
            end
            // Unselected measurements keep their last values on the serial side
            d.ser.rms[i] = d.chan[i].rmsRes;
            d.ser.peak[i] = d.chan[i].peakRes;
            d.ser.thr[i] = d.chan[i].thrRes;
          end
        end
        else
        begin
          // Inside a period: fold in this cycle's sample
          d.timer = q.timer - 24'h000001;
          d.first = 1'b0;
          for (int i = 0; i < 2; i++)
          begin
            d.chan[i].holder = peakNow[i];
            d.chan[i].acc = accNow[i];
            d.chan[i].cnt = cntNow[i];
          end
        end
      end
    endcase
  end

  // ========================================================================
  // State register

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.state <= ASM_IDLE;
      q.ctrl <= `ASM_RST_CTRL;
      q.serCtl <= `ASM_RST_SER;
      q.period <= `ASM_RST_PERIOD;
    end
    else
    begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs, all from flops

  assign regAns = q.ans;
  assign serOut = q.ser;

endmodule

`default_nettype wire

// [src/asm_pkg.sv]
// Types shared by the signal monitor modules.
// Assumes asm_cfg.svh is on the include path.
`include "asm_cfg.svh"

package asm_pkg;

  // ========================================================================
  // Data types
  typedef logic [13:0] asm_sample_t;
  typedef logic [12:0] asm_mag_t;
  typedef logic [19:0] asm_res_t;

  typedef enum logic {ASM_IDLE = 1'b0, ASM_RUN = 1'b1} asm_phase_t;

  // Register port request and answer
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [12:0] addr;
    logic [7:0] wrData;
  } asm_reg_req_t;

  typedef struct packed {
    logic rdValid;
    logic [7:0] rdData;
  } asm_reg_ans_t;

  // Serial monitor output words, one set per period
  typedef struct packed {
    logic valid;
    logic rmsEn;
    logic peakEn;
    logic thrEn;
    asm_res_t [1:0] rms;
    asm_mag_t [1:0] peak;
    asm_res_t [1:0] thr;
  } asm_ser_t;

  // Per-channel engine state
  typedef struct packed {
    asm_mag_t holder;
    logic [23:0] acc;
    logic [23:0] cnt;
    asm_res_t monResult;
    asm_mag_t peakRes;
    asm_res_t rmsRes;
    asm_res_t thrRes;
  } asm_chan_t;

  // Whole block state
  typedef struct packed {
    asm_phase_t state;
    logic [7:0] ctrl;
    logic [23:0] period;
    logic [7:0] serCtl;
    logic [2:0] onPrev;
    logic [23:0] timer;
    logic first;
    asm_reg_ans_t ans;
    asm_chan_t [1:0] chan;
    asm_ser_t ser;
  } asm_state_t;

endpackage
